//--- hw/acc_alu.sv
// Accumulator add and AND execution slice with AXI4-Lite register view.
// Assumes decoder presents a request with its memory byte already read.
// Functional notes
// - Add accumulator to memory, write back, four flags
// - AND memory into accumulator, zero flag only
// - AND immediate into accumulator, zero flag only
// - AND into memory, accumulator unchanged
`timescale 1ns/10ps
`default_nettype none
module acc_alu
  import acc_alu_pkg::*;
#(
  parameter int DATA_W = 8 // Datapath width
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic req_valid_i, // Request valid, one cycle
  input wire alu_req_t req_i, // Decoded request
  output mem_wb_t wb_o, // Memory write-back
  output logic [7:0] accumulator_o, // Accumulator value
  output logic [3:0] flags_o, // Overflow, zero, half carry, carry
  input wire logic [3:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [3:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read response valid
  input wire logic s_axi_rready // Read response ready
);
  // Width check: the flag logic is built for bytes
  if (DATA_W != 8) begin : g_bad_width
    $error("acc_alu supports only DATA_W of 8");
  end

  // Zero detect shared by every flag-writing operation
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  logic [7:0] acc_r; // Accumulator
  logic [3:0] flags_r; // Status flags
  logic [15:0] count_r; // Executed instruction count
  logic [8:0] sum; // Full sum with carry
  logic [4:0] nib_sum; // Low nibble sum
  logic [7:0] conj; // Bitwise AND of acc and memory
  logic [7:0] conj_imm; // Bitwise AND of acc and immediate
  logic signed_ovf; // Signed overflow
  // Write channel capture
  logic aw_hold_r; // Address taken
  logic w_hold_r; // Data taken
  logic [3:0] aw_addr_r; // Captured address
  logic [31:0] w_data_r; // Captured data
  logic [3:0] w_strb_r; // Captured strobes
  logic sw_acc_we; // Software write to accumulator
  logic sw_flags_we; // Software write to flags
  logic wr_go; // Both halves present

  // Arithmetic for the add and the two AND forms
  always_comb begin
    sum = {1'b0, acc_r} + {1'b0, req_i.mem};
    nib_sum = {1'b0, acc_r[3:0]} + {1'b0, req_i.mem[3:0]};
    signed_ovf = (acc_r[7] == req_i.mem[7]) && (sum[7] != acc_r[7]);
    conj = acc_r & req_i.mem;
    conj_imm = acc_r & req_i.imm;
  end

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign sw_acc_we = wr_go && aw_addr_r == ACC_OFFS && w_strb_r[0];
  assign sw_flags_we = wr_go && aw_addr_r == FLAGS_OFFS && w_strb_r[0];

  // Accumulator: instruction results win over software writes
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= ACC_RESET;
    end else if (req_valid_i && req_i.op == OP_AND_MEM_TO_ACC) begin
      acc_r <= conj;
    end else if (req_valid_i && req_i.op == OP_AND_IMM_TO_ACC) begin
      acc_r <= conj_imm;
    end else if (sw_acc_we) begin
      acc_r <= w_data_r[7:0];
    end
  end

  // Status flags, updated per operation
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= FLAGS_RESET;
    end else if (req_valid_i) begin
      case (req_i.op)
        OP_ADD_ACC_INTO_MEMORY: begin
          flags_r[FLAG_C_BIT] <= sum[8];
          flags_r[FLAG_HALF_CARRY_BIT] <= nib_sum[4];
          flags_r[FLAG_Z_BIT] <= is_zero(sum[7:0]);
          flags_r[FLAG_OVERFLOW_BIT] <= signed_ovf;
        end
        OP_AND_MEM_TO_ACC: begin
          flags_r[FLAG_Z_BIT] <= is_zero(conj);
        end
        OP_AND_IMM_TO_ACC: begin
          flags_r[FLAG_Z_BIT] <= is_zero(conj_imm);
        end
        OP_BITWISE_CONJUNCTION_INTO_MEMORY: begin
          flags_r[FLAG_Z_BIT] <= is_zero(conj);
        end
        default: begin
          // No instruction flag change, so a software write still lands
          if (sw_flags_we) begin
            flags_r <= w_data_r[3:0];
          end
        end
      endcase
    end else if (sw_flags_we) begin
      flags_r <= w_data_r[3:0];
    end
  end

  // Memory write-back strobe and data
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_o <= '0;
    end else if (req_valid_i && req_i.op == OP_ADD_ACC_INTO_MEMORY) begin
      wb_o <= '{we: 1'b1, data: sum[7:0]};
    end else if (req_valid_i &&
                 req_i.op == OP_BITWISE_CONJUNCTION_INTO_MEMORY) begin
      wb_o <= '{we: 1'b1, data: conj};
    end else begin
      wb_o.we <= 1'b0; // Data held, strobe dropped
    end
  end

  // Instruction counter, readable by software
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= 16'h0000;
    end else if (req_valid_i && req_i.op != OP_NONE) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Mirrors of state onto outputs, registered
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator_o <= ACC_RESET;
      flags_o <= FLAGS_RESET;
    end else begin
      accumulator_o <= acc_r;
      flags_o <= flags_r;
    end
  end

  // Write address capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, SLVERR for unmapped or read-only words
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r == ACC_OFFS || aw_addr_r == FLAGS_OFFS) ?
                     RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ACC_OFFS: s_axi_rdata <= {24'h000000, acc_r};
        FLAGS_OFFS: s_axi_rdata <= {28'h0000000, flags_r};
        COUNT_OFFS: s_axi_rdata <= {16'h0000, count_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // acc_alu
`default_nettype wire

//--- hw/acc_alu_pkg.sv
// Package for the accumulator add/AND datapath slice.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register port.
package acc_alu_pkg;
  // Operation codes issued by the instruction decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_ACC_INTO_MEMORY,
    OP_AND_MEM_TO_ACC,
    OP_AND_IMM_TO_ACC,
    OP_BITWISE_CONJUNCTION_INTO_MEMORY
  } alu_op_t;

  // One decoded instruction with its operand
  typedef struct packed {
    alu_op_t    op;   // Operation
    logic [7:0] mem;  // Data memory byte read at [m]
    logic [7:0] imm;  // Immediate operand
  } alu_req_t;

  // Memory write-back
  typedef struct packed {
    logic       we;   // Write strobe, one cycle
    logic [7:0] data; // Byte to store at [m]
  } mem_wb_t;

  // Status flag bit positions
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_HALF_CARRY_BIT = 1;
  localparam int FLAG_Z_BIT = 2;
  localparam int FLAG_OVERFLOW_BIT = 3;

  // Register byte offsets
  localparam logic [3:0] ACC_OFFS = 4'h0;
  localparam logic [3:0] FLAGS_OFFS = 4'h4;
  localparam logic [3:0] COUNT_OFFS = 4'h8;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sim/acc_alu_sva.sv
// Checker on the datapath ports of acc_alu.
// Assumes software leaves the accumulator alone near an instruction.
`timescale 1ns/10ps
`default_nettype none
module acc_alu_sva
  import acc_alu_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic req_valid_i, // Strobe
  input wire alu_req_t req_i, // Request
  input wire mem_wb_t wb_o, // Write-back
  input wire logic [7:0] accumulator_o, // Accumulator
  input wire logic [3:0] flags_o // Flags
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [8:0] sum9; // Sum with carry
  logic [7:0] and_m; // AND with memory
  logic [7:0] and_i; // AND with immediate
  logic [4:0] nib5; // Low nibble sum
  logic [3:0] add_flags; // Flags an add should give
  logic [2:0] other_flags; // Flags an AND must leave alone
  assign sum9 = {1'b0, accumulator_o} + {1'b0, req_i.mem};
  assign and_m = accumulator_o & req_i.mem;
  assign and_i = accumulator_o & req_i.imm;
  assign nib5 = {1'b0, accumulator_o[3:0]} + {1'b0, req_i.mem[3:0]};
  assign other_flags = {flags_o[FLAG_OVERFLOW_BIT],
    flags_o[FLAG_HALF_CARRY_BIT], flags_o[FLAG_C_BIT]};
  // Expected add flags: carry out, nibble carry, zero, signed overflow
  always_comb begin
    add_flags = 4'h0;
    add_flags[FLAG_C_BIT] = sum9[8];
    add_flags[FLAG_HALF_CARRY_BIT] = nib5[4];
    add_flags[FLAG_Z_BIT] = sum9[7:0] == 8'h00;
    add_flags[FLAG_OVERFLOW_BIT] = (accumulator_o[7] == req_i.mem[7]) &&
      (sum9[7] != accumulator_o[7]);
  end
  // Lone request, so the accumulator output is current
  sequence go(alu_op_t o);
    req_valid_i && req_i.op == o && !$past(req_valid_i);
  endsequence
  chk_add_wb: assert property (go(OP_ADD_ACC_INTO_MEMORY) |=>
    wb_o.we && wb_o.data == $past(sum9[7:0])) else $error("add wb");
  chk_add_carry: assert property (go(OP_ADD_ACC_INTO_MEMORY) |-> ##2
    flags_o[FLAG_C_BIT] == $past(sum9[8], 2)) else $error("carry");
  chk_and_mem: assert property (go(OP_AND_MEM_TO_ACC) |-> ##2
    accumulator_o == $past(and_m, 2)) else $error("and mem");
  chk_and_imm: assert property (go(OP_AND_IMM_TO_ACC) |-> ##2
    accumulator_o == $past(and_i, 2)) else $error("and imm");
  chk_into_mem: assert property (go(OP_BITWISE_CONJUNCTION_INTO_MEMORY)
    |=> wb_o.we && wb_o.data == $past(and_m) ##1
    accumulator_o == $past(accumulator_o, 2)) else $error("and wb");
  chk_zero_flag: assert property (go(OP_AND_IMM_TO_ACC) |-> ##2
    flags_o[FLAG_Z_BIT] == ($past(and_i, 2) == 8'h00)) else $error("zero");
  chk_add_flags: assert property (go(OP_ADD_ACC_INTO_MEMORY) |-> ##2
    flags_o == $past(add_flags, 2)) else $error("add flags");
  chk_and_keeps_flags: assert property (go(OP_AND_MEM_TO_ACC) |-> ##2
    other_flags == $past(other_flags)) else $error("and flags");
endmodule // acc_alu_sva
`default_nettype wire

//--- sim/accumulator_add_and_logic_bench.sv
// Bench for acc_alu: instruction table, then register and edge cases.
// Assumes acc_alu_sva is compiled beside it.
`timescale 1ns/10ps
`default_nettype none
module accumulator_add_and_logic_bench import acc_alu_pkg::*;;
  typedef struct packed {
    alu_op_t op;
    logic [7:0] a, m, i, r; // Acc, memory, immediate, result
    logic [3:0] f0, f; // Flags before and after
  } row_t;
  row_t rows [5] = '{
    '{OP_ADD_ACC_INTO_MEMORY, 8'hff, 8'h01, 8'h00, 8'h00, 4'h0, 4'h7},
    '{OP_ADD_ACC_INTO_MEMORY, 8'h7f, 8'h01, 8'h00, 8'h80, 4'h0, 4'ha},
    '{OP_AND_MEM_TO_ACC, 8'hf0, 8'h0f, 8'hff, 8'h00, 4'hb, 4'hf},
    '{OP_AND_IMM_TO_ACC, 8'h3c, 8'h00, 8'hf5, 8'h34, 4'h4, 4'h0},
    '{OP_BITWISE_CONJUNCTION_INTO_MEMORY, 8'ha5, 8'h0f, 8'hff, 8'h05,
      4'hb, 4'hb}};
  logic clk = 1'b0, rst_n = 1'b0, rv = 1'b0; // Clock, reset, strobe
  alu_req_t rq = '0; // Request
  mem_wb_t wb; // Write-back seen
  logic [7:0] acc; // Accumulator seen
  logic [3:0] flg, awa = '0, ara = '0; // Flags, addresses
  logic [3:0] ws = 4'hf; // Write strobes
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0; // Master strobes
  logic awr, wr_r, bv, arr, rv_o, wbx; // Slave strobes, expected write strobe
  logic [1:0] bres, rres, rs; // Responses
  logic [31:0] wd = '0, rdat, d; // Data
  int num_errors = 0, cmp_count = 0;
  acc_alu dut (.sys_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(rv),
    .req_i(rq), .wb_o(wb), .accumulator_o(acc), .flags_o(flg),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bres), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rres),
    .s_axi_rvalid(rv_o), .s_axi_rready(rr));
  always #4 clk = ~clk;
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // AXI write, both channels offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    rs = bres;
  endtask
  // AXI read
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv_o);
    rr <= 1'b0;
    d = rdat;
    rs = rres;
  endtask
  // Print counts and verdict
  task end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Table of lone instructions
    foreach (rows[k]) begin
      wr(ACC_OFFS, {24'h0, rows[k].a});
      wr(FLAGS_OFFS, {28'h0, rows[k].f0});
      @(posedge clk);
      rv <= 1'b1;
      rq <= '{rows[k].op, rows[k].m, rows[k].i};
      @(posedge clk);
      rv <= 1'b0;
      #1;
      wbx = rows[k].op inside {OP_ADD_ACC_INTO_MEMORY,
        OP_BITWISE_CONJUNCTION_INTO_MEMORY};
      chk(32'(wb.we), 32'(wbx));
      if (wbx) chk(32'(wb.data), 32'(rows[k].r));
      @(posedge clk);
      #1;
      chk(32'(acc), 32'(wbx ? rows[k].a : rows[k].r));
      chk(32'(flg), 32'(rows[k].f));
    end
    // Back to back: AND immediate then add
    wr(ACC_OFFS, 32'hff);
    @(posedge clk);
    rv <= 1'b1;
    rq <= '{OP_AND_IMM_TO_ACC, 8'h00, 8'h0f};
    @(posedge clk);
    rq <= '{OP_ADD_ACC_INTO_MEMORY, 8'hf1, 8'h00};
    @(posedge clk);
    rv <= 1'b0;
    #1;
    chk(32'({wb.we, wb.data}), 32'h100);
    @(posedge clk);
    #1;
    chk(32'({acc, flg}), 32'h0f7);
    // Refused accesses
    rd(4'hc);
    chk({d[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(COUNT_OFFS, 32'h1);
    chk(32'(rs), 32'(RESP_SLVERR));
    // Seven instructions ran, none of them empty
    rd(COUNT_OFFS);
    chk({d[29:0], rs}, {14'h0, 16'h0007, RESP_OKAY});
    // Reset in mid-run clears the registers
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ACC_OFFS);
    chk({d[29:0], rs}, {22'h0, ACC_RESET, RESP_OKAY});
    rd(FLAGS_OFFS);
    chk({d[29:0], rs}, {26'h0, FLAGS_RESET, RESP_OKAY});
    chk(32'({acc, flg, wb.we}), 32'h0);
    rd(COUNT_OFFS);
    chk({d[29:0], rs}, {30'h0, RESP_OKAY});
    // Without byte lane 0 the accumulator write is dropped
    ws <= 4'he;
    wr(ACC_OFFS, 32'h5a);
    chk(32'(rs), 32'(RESP_OKAY));
    rd(ACC_OFFS);
    chk({d[29:0], rs}, {22'h0, ACC_RESET, RESP_OKAY});
    ws <= 4'hf;
    end_of_test;
  end
  // Watchdog
  initial begin
    #40000;
    num_errors++;
    end_of_test;
  end
endmodule // accumulator_add_and_logic_bench
bind acc_alu acc_alu_sva chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .wb_o(wb_o),
  .accumulator_o(accumulator_o), .flags_o(flags_o));
`default_nettype wire
